// file: rtl/aiqx_exec_unit.sv
// Decode and execute unit for add-immediate, add-quick and add-with-extend, Avalon-MM slave
//
// Chosen here: the register addresses and the Avalon-MM register port.
module aiqx_exec_unit (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             exec_done,
  output logic             illegal_instr
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [15:0]             opcode;
  logic [15:0]             ext0;
  logic [15:0]             ext1;
  logic [31:0]             dst_val;
  logic [31:0]             src_val;
  logic [4:0]              ccr;
  logic [31:0]             result;
  logic                    wrote_back;
  aiqx_pkg::aiqx_dec_t     dec;
  aiqx_pkg::aiqx_dec_t     last_dec;
  aiqx_pkg::aiqx_state_t   state;
  aiqx_pkg::aiqx_state_t   next_state;
  logic                    rd_ack;
  logic                    start;
  logic [31:0]             next_result;
  logic [4:0]              next_ccr;
  logic                    next_wb;
  logic [31:0]             status_word;

  // Byte-lane merge for partial Avalon writes
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  // Writes complete at once; reads stall one cycle so read data comes from a flop
  assign avs_waitrequest = avs_read & ~rd_ack;
  assign start = avs_write & (avs_address[5:2] == aiqx_pkg::OFS_CTRL[5:2]) & avs_byteenable[0]
                 & avs_writedata[0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_ack <= 1'b0;
    end else begin
      rd_ack <= avs_read & ~rd_ack;
    end
  end

  // Status word layout shown to software
  assign status_word = {17'h0_0000, last_dec.ext_words, last_dec.mem_form, last_dec.addr_dst,
                        last_dec.src_reg, last_dec.dst_reg, last_dec.kind, wrote_back,
                        illegal_instr, exec_done};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= aiqx_pkg::WORD_RST;
    end else if (avs_read & ~rd_ack) begin
      case (avs_address[5:2])
        aiqx_pkg::OFS_OPCODE[5:2]: avs_readdata <= {16'h0000, opcode};
        aiqx_pkg::OFS_EXT0[5:2]:   avs_readdata <= {16'h0000, ext0};
        aiqx_pkg::OFS_EXT1[5:2]:   avs_readdata <= {16'h0000, ext1};
        aiqx_pkg::OFS_DST[5:2]:    avs_readdata <= dst_val;
        aiqx_pkg::OFS_SRC[5:2]:    avs_readdata <= src_val;
        aiqx_pkg::OFS_CCR[5:2]:    avs_readdata <= {27'h000_0000, ccr};
        aiqx_pkg::OFS_RESULT[5:2]: avs_readdata <= result;
        aiqx_pkg::OFS_STATUS[5:2]: avs_readdata <= status_word;
        default:                   avs_readdata <= aiqx_pkg::WORD_RST;
      endcase
    end
  end

  // Operand registers written by software
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      opcode  <= 16'h0000;
      ext0    <= 16'h0000;
      ext1    <= 16'h0000;
      dst_val <= aiqx_pkg::WORD_RST;
      src_val <= aiqx_pkg::WORD_RST;
    end else if (avs_write) begin
      case (avs_address[5:2])
        aiqx_pkg::OFS_OPCODE[5:2]: opcode  <= 16'(be_merge({16'h0000, opcode}, avs_writedata, avs_byteenable));
        aiqx_pkg::OFS_EXT0[5:2]:   ext0    <= 16'(be_merge({16'h0000, ext0}, avs_writedata, avs_byteenable));
        aiqx_pkg::OFS_EXT1[5:2]:   ext1    <= 16'(be_merge({16'h0000, ext1}, avs_writedata, avs_byteenable));
        aiqx_pkg::OFS_DST[5:2]:    dst_val <= be_merge(dst_val, avs_writedata, avs_byteenable);
        aiqx_pkg::OFS_SRC[5:2]:    src_val <= be_merge(src_val, avs_writedata, avs_byteenable);
        default:                   ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  // Classify the opcode, pick the constant and check the destination mode
  always_comb begin
    logic [2:0] mode;
    logic [2:0] rg;
    logic       size_ok;
    logic       alterable;
    mode      = opcode[5:3];
    rg        = opcode[2:0];
    size_ok   = (opcode[7:6] != 2'h3);
    alterable = (mode != aiqx_pkg::EA_EXT) || (rg == aiqx_pkg::EA_ABSW) || (rg == aiqx_pkg::EA_ABSL);
    dec           = '0;
    dec.size      = opcode[7:6];
    dec.dst_reg   = opcode[11:9];
    dec.src_reg   = opcode[2:0];
    if (opcode[15:8] == aiqx_pkg::OPC_ADD_IMMEDIATE_OP_HI) begin
      dec.kind    = aiqx_pkg::AIQX_ADD_IMMEDIATE_OP;
      dec.dst_reg = rg;
      dec.src_reg = 3'h0;
      dec.legal   = size_ok && alterable && (mode != aiqx_pkg::EA_AREG);
      case (opcode[7:6])
        aiqx_pkg::SZ_BYTE: begin
          dec.imm       = {24'h00_0000, ext0[7:0]};
          dec.ext_words = 2'h1;
        end
        aiqx_pkg::SZ_WORD: begin
          dec.imm       = {16'h0000, ext0};
          dec.ext_words = 2'h1;
        end
        aiqx_pkg::SZ_LONG: begin
          dec.imm       = {ext0, ext1};
          dec.ext_words = 2'h2;
        end
        default: begin
          dec.imm       = aiqx_pkg::WORD_RST;
          dec.ext_words = 2'h0;
        end
      endcase
    end else if ((opcode[15:12] == aiqx_pkg::OPC_ADD_QUICK_OP_HI) && !opcode[8]) begin
      dec.kind     = aiqx_pkg::AIQX_ADD_QUICK_OP;
      dec.dst_reg  = rg;
      dec.src_reg  = 3'h0;
      dec.addr_dst = (mode == aiqx_pkg::EA_AREG);
      dec.imm      = {28'h000_0000, (opcode[11:9] == 3'h0), opcode[11:9]};
      dec.legal    = size_ok && alterable
                     && !(dec.addr_dst && (opcode[7:6] == aiqx_pkg::SZ_BYTE));
    end else if ((opcode[15:12] == aiqx_pkg::OPC_ADD_WITH_EXTEND_OP_HI) && opcode[8] && (opcode[5:4] == 2'h0)) begin
      dec.kind     = aiqx_pkg::AIQX_ADD_WITH_EXTEND_OP;
      dec.mem_form = opcode[3];
      dec.dst_reg  = opcode[11:9];
      dec.src_reg  = opcode[2:0];
      dec.imm      = src_val;
      dec.legal    = size_ok;
    end else begin
      dec.legal = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Adder and flags

  // Operands are shifted so the chosen width's top bit sits at bit 31; the
  // carry then always falls out at bit 32 and one adder serves all sizes
  always_comb begin
    logic [4:0]  sh;
    logic [31:0] mask;
    logic [31:0] a_sh;
    logic [31:0] b_sh;
    logic [31:0] x_sh;
    logic [32:0] sum;
    logic [31:0] narrow;
    logic        carry;
    logic        ovf;
    logic        zero;
    sh = aiqx_pkg::SH_LONG;
    case (dec.size)
      aiqx_pkg::SZ_BYTE: sh = aiqx_pkg::SH_BYTE;
      aiqx_pkg::SZ_WORD: sh = aiqx_pkg::SH_WORD;
      default:           sh = aiqx_pkg::SH_LONG;
    endcase
    mask   = 32'hFFFF_FFFF >> sh;
    a_sh   = dst_val << sh;
    b_sh   = dec.imm << sh;
    x_sh   = (dec.kind == aiqx_pkg::AIQX_ADD_WITH_EXTEND_OP) ? ({31'h0000_0000, ccr[aiqx_pkg::CCR_X]} << sh)
                                               : 32'h0000_0000;
    sum    = {1'b0, a_sh} + {1'b0, b_sh} + {1'b0, x_sh};
    carry  = sum[32];
    ovf    = (a_sh[31] == b_sh[31]) && (sum[31] != a_sh[31]);
    zero   = (sum[31:0] == 32'h0000_0000);
    narrow = sum[31:0] >> sh;
    next_ccr    = ccr;
    next_wb     = dec.legal;
    next_result = (dst_val & ~mask) | (narrow & mask);
    if (!dec.legal) begin
      next_result = dst_val;
    end else if (dec.addr_dst) begin
      next_result = dst_val + dec.imm;
    end else begin
      next_ccr[aiqx_pkg::CCR_C] = carry;
      next_ccr[aiqx_pkg::CCR_X] = carry;
      next_ccr[aiqx_pkg::CCR_V] = ovf;
      next_ccr[aiqx_pkg::CCR_N] = sum[31];
      if (dec.kind == aiqx_pkg::AIQX_ADD_WITH_EXTEND_OP) begin
        next_ccr[aiqx_pkg::CCR_Z] = zero ? ccr[aiqx_pkg::CCR_Z] : 1'b0;
      end else begin
        next_ccr[aiqx_pkg::CCR_Z] = zero;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Start begins one cycle of execution on the live operand registers, then results stand
  always_comb begin
    case (state)
      aiqx_pkg::ST_IDLE: next_state = start ? aiqx_pkg::ST_EXEC : aiqx_pkg::ST_IDLE;
      aiqx_pkg::ST_EXEC: next_state = aiqx_pkg::ST_DONE;
      aiqx_pkg::ST_DONE: next_state = start ? aiqx_pkg::ST_EXEC : aiqx_pkg::ST_DONE;
      default:           next_state = aiqx_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= aiqx_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Execution results; a start during execution is ignored
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      result        <= aiqx_pkg::WORD_RST;
      wrote_back    <= 1'b0;
      illegal_instr <= 1'b0;
      exec_done     <= 1'b0;
      last_dec      <= '0;
    end else if (state == aiqx_pkg::ST_EXEC) begin
      result        <= next_result;
      wrote_back    <= next_wb;
      illegal_instr <= ~dec.legal;
      exec_done     <= 1'b1;
      last_dec      <= dec;
    end else if (start) begin
      exec_done     <= 1'b0;
    end
  end

  // Flags: execution wins over a software write in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ccr <= aiqx_pkg::CCR_RST;
    end else if (state == aiqx_pkg::ST_EXEC) begin
      ccr <= next_ccr;
    end else if (avs_write && (avs_address[5:2] == aiqx_pkg::OFS_CCR[5:2]) && avs_byteenable[0]) begin
      ccr <= avs_writedata[4:0];
    end
  end

endmodule

// file: rtl/aiqx_pkg.sv
// Shared constants, types and register map of the add-immediate/quick/extended execution unit
package aiqx_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [5:0] OFS_OPCODE = 6'h00;
  localparam logic [5:0] OFS_EXT0   = 6'h04;
  localparam logic [5:0] OFS_EXT1   = 6'h08;
  localparam logic [5:0] OFS_DST    = 6'h0C;
  localparam logic [5:0] OFS_SRC    = 6'h10;
  localparam logic [5:0] OFS_CCR    = 6'h14;
  localparam logic [5:0] OFS_CTRL   = 6'h18;
  localparam logic [5:0] OFS_RESULT = 6'h1C;
  localparam logic [5:0] OFS_STATUS = 6'h20;

  // Condition code bit positions
  localparam int CCR_C = 0;
  localparam int CCR_V = 1;
  localparam int CCR_Z = 2;
  localparam int CCR_N = 3;
  localparam int CCR_X = 4;

  // Reset values
  localparam logic [4:0]  CCR_RST  = 5'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // Size field codes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;

  // Shift that aligns an operand's top bit with bit 31
  localparam logic [4:0] SH_BYTE = 5'h18;
  localparam logic [4:0] SH_WORD = 5'h10;
  localparam logic [4:0] SH_LONG = 5'h00;

  // Effective address mode codes
  localparam logic [2:0] EA_DREG = 3'h0;
  localparam logic [2:0] EA_AREG = 3'h1;
  localparam logic [2:0] EA_EXT  = 3'h7;
  localparam logic [2:0] EA_ABSW = 3'h0;
  localparam logic [2:0] EA_ABSL = 3'h1;

  // Opcode patterns
  localparam logic [7:0] OPC_ADD_IMMEDIATE_OP_HI = 8'h06;
  localparam logic [3:0] OPC_ADD_QUICK_OP_HI = 4'h5;
  localparam logic [3:0] OPC_ADD_WITH_EXTEND_OP_HI = 4'hD;

  typedef enum logic [1:0] {
    AIQX_NONE = 2'h0,
    AIQX_ADD_IMMEDIATE_OP = 2'h1,
    AIQX_ADD_QUICK_OP = 2'h2,
    AIQX_ADD_WITH_EXTEND_OP = 2'h3
  } aiqx_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DONE = 3'b100
  } aiqx_state_t;

  // Decoded instruction
  typedef struct packed {
    aiqx_kind_t  kind;
    logic        legal;
    logic [1:0]  size;
    logic        addr_dst;
    logic        mem_form;
    logic [2:0]  dst_reg;
    logic [2:0]  src_reg;
    logic [1:0]  ext_words;
    logic [31:0] imm;
  } aiqx_dec_t;

endpackage

// file: verification/aiqx_exec_unit_chk.sv
// Bus handshake and completion checks for the add execution unit
module aiqx_exec_unit_chk (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        exec_done,
  input wire logic        illegal_instr
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic start;
  // A start is a write of bit0 to the control word
  assign start = avs_write && (avs_address[5:2] == 4'h6) && avs_byteenable[0] && avs_writedata[0];
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  a_read_waits_first: assert property ($rose(avs_read) |-> avs_waitrequest) else $error("read not stalled");
  a_read_wait_once: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest) else $error("read stall long");
  a_write_no_wait: assert property (avs_write |-> !avs_waitrequest) else $error("write stalled");
  // A start in the exec cycle is ignored, so only a lone start is timed
  a_done_two_edges: assert property (start && !$past(start) |=> !exec_done ##1 exec_done)
    else $error("done not two edges after start");
  a_done_holds: assert property (exec_done && !start |=> exec_done) else $error("done dropped");
  a_done_cause: assert property ($rose(exec_done) |-> $past(start, 2)) else $error("done without start");
  a_illegal_cause: assert property ($changed(illegal_instr) |-> $past(start, 2))
    else $error("illegal flag moved without execution");
  a_rdata_holds: assert property (!$past(avs_read) |-> $stable(avs_readdata)) else $error("read data moved");
endmodule
bind aiqx_exec_unit aiqx_exec_unit_chk i_aiqx_exec_unit_chk (.clk(clk), .nrst(nrst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .exec_done(exec_done),
  .illegal_instr(illegal_instr));

// file: verification/aiqx_bus_model.sv
// Fetch-side model: Avalon-MM master that hands opcode, extension words and operands to the unit
module aiqx_bus_model (
  input  wire logic        clk,
  input  wire logic        avs_waitrequest,
  input  wire logic [31:0] avs_readdata,
  output logic      [5:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Request held until waitrequest is sampled low; extension words go in fetch order
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  // Data taken at the same edge that sees waitrequest low
  task automatic rd(input logic [5:0] a, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
  endtask
endmodule

// file: verification/aiqx_exec_unit_test.sv
// Self-checking bench for the add execution unit
module aiqx_exec_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        nrst = 1'b0;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        exec_done;
  logic        illegal_instr;
  logic [31:0] q;
  int          err_total = 0;
  int          checks = 0;
  int          cyc = 0;
  int          tnum = 0;
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  aiqx_exec_unit i_aiqx_exec_unit (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .exec_done(exec_done),
    .illegal_instr(illegal_instr));
  aiqx_bus_model i_bus (.clk(clk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Load one instruction, start it, wait for done, check result, flags and illegal status
  task automatic run(input logic [15:0] op, input logic [15:0] e0, input logic [15:0] e1, input logic [31:0] dst,
                     input logic [31:0] src, input logic [4:0] ccr, input logic [31:0] res,
                     input logic [4:0] eccr, input logic ill);
    int n;
    n = 0;
    i_bus.wr(aiqx_pkg::OFS_OPCODE, {16'h0000, op});
    i_bus.wr(aiqx_pkg::OFS_EXT0, {16'h0000, e0});
    i_bus.wr(aiqx_pkg::OFS_EXT1, {16'h0000, e1});
    i_bus.wr(aiqx_pkg::OFS_DST, dst);
    i_bus.wr(aiqx_pkg::OFS_SRC, src);
    i_bus.wr(aiqx_pkg::OFS_CCR, {27'h0000000, ccr});
    i_bus.wr(aiqx_pkg::OFS_CTRL, 32'h0000_0001);
    // Bounded wait: a unit that never finishes is caught here, not by the global limit
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (exec_done !== 1'b1 && n < 20);
    cmp({31'h0, exec_done}, 32'h0000_0001);
    cmp({31'h0, illegal_instr}, {31'h0, ill});
    i_bus.rd(aiqx_pkg::OFS_RESULT, q);
    cmp(q, res);
    i_bus.rd(aiqx_pkg::OFS_CCR, q);
    cmp({27'h0000000, q[4:0]}, {27'h0000000, eccr});
    tnum++;
    $display("test %0d done", tnum);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1;
    cmp({30'h0, exec_done, illegal_instr}, 32'h0000_0000);
    cmp(avs_readdata, 32'h0000_0000);
    run(16'h0600, 16'hAB01, 16'h0000, 32'h1234_56FF, 32'h0000_0000, 5'h00, 32'h1234_5600, 5'h15, 1'b0);
    run(16'h0668, 16'h7FFF, 16'h0000, 32'hAAAA_0001, 32'h0000_0000, 5'h15, 32'hAAAA_8000, 5'h0A, 1'b0);
    run(16'h06B9, 16'h8000, 16'h0001, 32'h8000_0000, 32'h0000_0000, 5'h00, 32'h0000_0001, 5'h13, 1'b0);
    run(16'h0608, 16'h0001, 16'h0000, 32'h1111_1111, 32'h0000_0000, 5'h04, 32'h1111_1111, 5'h04, 1'b1);
    run(16'h063A, 16'h0001, 16'h0000, 32'h2222_2222, 32'h0000_0000, 5'h01, 32'h2222_2222, 5'h01, 1'b1);
    run(16'h06C0, 16'h0001, 16'h0000, 32'h3333_3333, 32'h0000_0000, 5'h0A, 32'h3333_3333, 5'h0A, 1'b1);
    run(16'h5000, 16'h0000, 16'h0000, 32'h0000_00FA, 32'h0000_0000, 5'h00, 32'h0000_0002, 5'h11, 1'b0);
    run(16'h5E41, 16'h0000, 16'h0000, 32'hFFFF_7FFA, 32'h0000_0000, 5'h00, 32'hFFFF_8001, 5'h0A, 1'b0);
    run(16'h528A, 16'h0000, 16'h0000, 32'hFFFF_FFFF, 32'h0000_0000, 5'h0A, 32'h0000_0000, 5'h0A, 1'b0);
    run(16'h5648, 16'h0000, 16'h0000, 32'h0000_FFFF, 32'h0000_0000, 5'h00, 32'h0001_0002, 5'h00, 1'b0);
    run(16'h5208, 16'h0000, 16'h0000, 32'h5555_5555, 32'h0000_0000, 5'h00, 32'h5555_5555, 5'h00, 1'b1);
    run(16'hD101, 16'h0000, 16'h0000, 32'h0000_0010, 32'h0000_00EF, 5'h14, 32'h0000_0000, 5'h15, 1'b0);
    run(16'hD549, 16'h0000, 16'h0000, 32'h0000_0001, 32'h0000_0000, 5'h04, 32'h0000_0001, 5'h00, 1'b0);
    i_bus.rd(aiqx_pkg::OFS_STATUS, q);
    cmp({25'h0000000, q[12], q[10:5]}, {25'h0000000, 1'b1, 3'h1, 3'h2});
    run(16'hD180, 16'h0000, 16'h0000, 32'h7FFF_FFFF, 32'h0000_0000, 5'h10, 32'h8000_0000, 5'h0A, 1'b0);
    run(16'hD1C0, 16'h0000, 16'h0000, 32'h4444_4444, 32'h0000_0001, 5'h10, 32'h4444_4444, 5'h10, 1'b1);
    i_bus.rd(aiqx_pkg::OFS_CTRL, q);
    cmp(q, 32'h0000_0000);
    i_bus.rd(6'h3C, q);
    cmp(q, 32'h0000_0000);
    $display("bus map test done");
    end_sim();
  end
endmodule
